//--- fap_pkg.sv
// Constants shared by the flood and access-list policing stage
`default_nettype none
package fap_pkg;
    // Bus and datapath widths
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int LEN_W = 14;
    localparam int FILL_W = 24;
    // Address regions, taken from the top two address bits
    localparam logic [1:0] RGN_GLOBAL = 2'h0;
    localparam logic [1:0] RGN_FLOOD = 2'h1;
    localparam logic [1:0] RGN_LIST = 2'h2;
    localparam logic [1:0] RGN_PORT = 2'h3;
    localparam logic [9:0] OFF_GLOBAL = 10'h000;
    localparam logic [9:0] OFF_STICKY = 10'h004;
    // Global control word fields
    localparam int GL_PRIO_EN = 0;
    localparam int GL_GREEN_LO = 1;
    localparam int GL_PORT_CNT = 3;
    localparam int GL_STAT_LO = 8;
    localparam int GL_TMASK_LO = 16;
    localparam int GL_TMASK_STEP = 4;
    // Flood policer configuration word fields
    localparam int FC_GRAN_LO = 0;
    localparam int FC_STEP_LO = 2;
    localparam int FC_GAP_LO = 4;
    localparam int FC_SKIP = 11;
    localparam int FC_FRAMES = 12;
    // Flood bucket word fields
    localparam int FB_THR_LO = 0;
    localparam int FB_RATE_LO = 16;
    // Access-list control and rate word fields
    localparam int LC_TGT_LO = 0;
    localparam int LC_FRAMES = 2;
    localparam int LC_BYP_LO = 3;
    localparam int LC_GAP_LO = 8;
    localparam int LR_RATE_LO = 0;
    localparam int LR_THR_LO = 24;
    // Target select bits of an access-list policer
    localparam int TGT_FRONT = 0;
    localparam int TGT_CPU = 1;
    // Sticky debug flag positions
    localparam int FLG_PIPE = 0;
    localparam int FLG_LEVEL = 1;
    localparam int FLG_DROP = 2;
    localparam int FLG_ACTIVE = 3;
    // Burst limit units and frame-mode rate multiplier
    localparam int FLOOD_THR_SHIFT = 11;
    localparam int LIST_THR_SHIFT = 12;
    localparam int LIST_FRAME_MULT = 10;
    // Reset values
    localparam logic [1:0] RST_GREEN = 2'h3;
    localparam logic [5:0] RST_STAT_MASK = 6'h00;
    // Leak tick timing
    localparam int CLK_NS = 50;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
endpackage : fap_pkg
`default_nettype wire

//--- fap_policer.sv
// Flood, access-list and priority policing stage with its register port
`timescale 1ns/1ps
`default_nettype none
module fap_policer #(
    parameter int NUM_FLOOD = 4,
    parameter int NUM_LIST = 8,
    parameter int NUM_PORT = 8,
    parameter int SVC_W = 12,
    parameter int DB_W = 10,
    parameter int TICK_CYCLES = fap_pkg::TICK_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [fap_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [fap_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [fap_pkg::DATA_W-1:0] reg_rdata,
    input wire logic frm_valid,
    input wire logic [fap_pkg::LEN_W-1:0] frm_len,
    input wire logic [6:0] frm_stripped,
    input wire logic [1:0] frm_prec,
    input wire logic [2:0] frm_flood_type,
    input wire logic [$clog2(NUM_FLOOD)-1:0] frm_vlan_flood_idx,
    input wire logic frm_service_flood_override,
    input wire logic [$clog2(NUM_FLOOD)-1:0] frm_svc_flood_idx,
    input wire logic frm_to_cpu,
    input wire logic frm_list_hit,
    input wire logic [$clog2(NUM_LIST)-1:0] frm_list_idx,
    input wire logic frm_pipeline_bypass,
    input wire logic [SVC_W-1:0] frm_service_index,
    input wire logic [DB_W-1:0] frm_service_policer_index,
    input wire logic frm_rule_policer_select_bit,
    input wire logic [DB_W-1:0] frm_rule_policer_idx,
    input wire logic [$clog2(NUM_PORT)-1:0] frm_port,
    input wire logic [2:0] frm_qos,
    output logic res_valid,
    output logic res_drop,
    output logic [1:0] res_prec,
    output logic res_dual_valid,
    output logic [DB_W-1:0] res_dual_idx,
    output logic res_dual_green,
    output logic [5:0] flood_stat_evt,
    output logic list_drop_evt,
    output logic list_drop_port_evt
);
    import fap_pkg::*;

    localparam int FI_W = $clog2(NUM_FLOOD);
    localparam int FK_W = $clog2(NUM_FLOOD * 3);
    localparam int LI_W = $clog2(NUM_LIST);
    localparam int PI_W = $clog2(NUM_PORT);
    localparam int TC_W = $clog2(TICK_CYCLES + 1);

    // Sizes that the address map or index widths cannot serve
    if (NUM_FLOOD < 2 || NUM_FLOOD > 64 || NUM_LIST < 2 || NUM_LIST > 128) begin : g_chk_pol
        $error("Policer count out of range");
    end
    if (NUM_PORT < 2 || NUM_PORT > 256 || TICK_CYCLES < 1 || DB_W < 3) begin : g_chk_misc
        $error("Port count, tick or index width out of range");
    end

    // Charged amount: frame unit, or length with gap and optional strip removal
    function automatic logic [FILL_W-1:0] charge_calc(input logic [LEN_W-1:0] len,
            input logic [6:0] stripped, input logic [6:0] gap, input logic skip,
            input logic frames);
        logic signed [15:0] s;
        s = $signed({2'b00, len}) + $signed({{9{gap[6]}}, gap});
        if (skip) begin
            s = s - $signed({9'h000, stripped});
        end
        if (frames) begin
            charge_calc = FILL_W'(1);
        end else if (s < 0) begin
            charge_calc = '0;
        end else begin
            charge_calc = {8'h00, s};
        end
    endfunction : charge_calc

    // One bucket update: leak with floor at zero, then saturating add
    function automatic logic [FILL_W-1:0] bucket_step(input logic [FILL_W-1:0] fill,
            input logic drain_en, input logic [FILL_W-1:0] drain, input logic add_en,
            input logic [FILL_W-1:0] add);
        logic [FILL_W-1:0] d;
        logic [FILL_W:0] s;
        d = fill;
        if (drain_en) begin
            d = (fill > drain) ? fill - drain : '0;
        end
        s = {1'b0, d} + {1'b0, add};
        bucket_step = !add_en ? d : (s[FILL_W] ? '1 : s[FILL_W-1:0]);
    endfunction : bucket_step

    // Configuration, bucket fill, sticky flag and tick state
    logic prio_en_r, port_cnt_r;
    logic [1:0] green_r;
    logic [5:0] stat_mask_r;
    logic [2:0] tmask_r [3];
    logic [3:0] flags_r;
    logic [1:0] fgran_r [NUM_FLOOD];
    logic [1:0] fstep_r [NUM_FLOOD];
    logic [6:0] fgap_r [NUM_FLOOD];
    logic fskip_r [NUM_FLOOD];
    logic fframes_r [NUM_FLOOD];
    logic [6:0] fthr_r [NUM_FLOOD*3];
    logic [10:0] frate_r [NUM_FLOOD*3];
    logic [FILL_W-1:0] ffill_r [NUM_FLOOD*3];
    logic [1:0] ltgt_r [NUM_LIST];
    logic lframes_r [NUM_LIST];
    logic [1:0] lbyp_r [NUM_LIST];
    logic [6:0] lgap_r [NUM_LIST];
    logic [16:0] lrate_r [NUM_LIST];
    logic [5:0] lthr_r [NUM_LIST];
    logic [FILL_W-1:0] lfill_r [NUM_LIST];
    logic [DB_W-1:0] pbase_r [NUM_PORT];
    logic [TC_W-1:0] tick_cnt_r;
    logic tick_r;

    // Register address decode
    wire [1:0] rgn = reg_addr[11:10];
    wire [5:0] f_sel = reg_addr[9:4];
    wire [1:0] f_word = reg_addr[3:2];
    wire [6:0] l_sel = reg_addr[9:3];
    wire l_word = reg_addr[2];
    wire [7:0] p_sel = reg_addr[9:2];
    wire f_ok = rgn == RGN_FLOOD && int'(f_sel) < NUM_FLOOD;
    wire l_ok = rgn == RGN_LIST && int'(l_sel) < NUM_LIST;
    wire p_ok = rgn == RGN_PORT && int'(p_sel) < NUM_PORT;
    wire g_ok = rgn == RGN_GLOBAL && reg_addr[9:0] == OFF_GLOBAL;
    wire s_ok = rgn == RGN_GLOBAL && reg_addr[9:0] == OFF_STICKY;
    wire [FI_W-1:0] f_idx = f_sel[FI_W-1:0];
    wire [LI_W-1:0] l_idx = l_sel[LI_W-1:0];
    wire [PI_W-1:0] p_idx = p_sel[PI_W-1:0];
    wire [FK_W-1:0] f_bkt = FK_W'(int'(f_idx) * 3 + (f_word == 2'h0 ? 0 : int'(f_word) - 1));

    // Configuration writes; ignored outside the mapped words
    always_ff @(posedge clk) begin
        if (rst) begin
            prio_en_r <= 1'b0;
            port_cnt_r <= 1'b0;
            green_r <= RST_GREEN;
            stat_mask_r <= RST_STAT_MASK;
            for (int b = 0; b < 3; b++) begin
                tmask_r[b] <= 3'h0;
            end
            for (int i = 0; i < NUM_FLOOD; i++) begin
                fgran_r[i] <= 2'h0;
                fstep_r[i] <= 2'h0;
                fgap_r[i] <= 7'h00;
                fskip_r[i] <= 1'b0;
                fframes_r[i] <= 1'b0;
            end
            for (int k = 0; k < NUM_FLOOD * 3; k++) begin
                fthr_r[k] <= 7'h00;
                frate_r[k] <= 11'h000;
            end
            for (int j = 0; j < NUM_LIST; j++) begin
                ltgt_r[j] <= 2'h0;
                lframes_r[j] <= 1'b0;
                lbyp_r[j] <= 2'h0;
                lgap_r[j] <= 7'h00;
                lrate_r[j] <= 17'h00000;
                lthr_r[j] <= 6'h00;
            end
            for (int p = 0; p < NUM_PORT; p++) begin
                pbase_r[p] <= '0;
            end
        end else if (reg_wr) begin
            if (g_ok) begin
                prio_en_r <= reg_wdata[GL_PRIO_EN];
                green_r <= reg_wdata[GL_GREEN_LO +: 2];
                port_cnt_r <= reg_wdata[GL_PORT_CNT];
                stat_mask_r <= reg_wdata[GL_STAT_LO +: 6];
                for (int b = 0; b < 3; b++) begin
                    tmask_r[b] <= reg_wdata[GL_TMASK_LO + b * GL_TMASK_STEP +: 3];
                end
            end
            if (f_ok && f_word == 2'h0) begin
                fgran_r[f_idx] <= reg_wdata[FC_GRAN_LO +: 2];
                fstep_r[f_idx] <= reg_wdata[FC_STEP_LO +: 2];
                fgap_r[f_idx] <= reg_wdata[FC_GAP_LO +: 7];
                fskip_r[f_idx] <= reg_wdata[FC_SKIP];
                fframes_r[f_idx] <= reg_wdata[FC_FRAMES];
            end
            if (f_ok && f_word != 2'h0) begin
                fthr_r[f_bkt] <= reg_wdata[FB_THR_LO +: 7];
                frate_r[f_bkt] <= reg_wdata[FB_RATE_LO +: 11];
            end
            if (l_ok && !l_word) begin
                ltgt_r[l_idx] <= reg_wdata[LC_TGT_LO +: 2];
                lframes_r[l_idx] <= reg_wdata[LC_FRAMES];
                lbyp_r[l_idx] <= reg_wdata[LC_BYP_LO +: 2];
                lgap_r[l_idx] <= reg_wdata[LC_GAP_LO +: 7];
            end
            if (l_ok && l_word) begin
                lrate_r[l_idx] <= reg_wdata[LR_RATE_LO +: 17];
                lthr_r[l_idx] <= reg_wdata[LR_THR_LO +: 6];
            end
            if (p_ok) begin
                pbase_r[p_idx] <= reg_wdata[DB_W-1:0];
            end
        end
    end

    // Leak tick divider, one-cycle enable pulse
    always_ff @(posedge clk) begin
        if (rst) begin
            tick_cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= (int'(tick_cnt_r) == TICK_CYCLES - 1);
            tick_cnt_r <= (int'(tick_cnt_r) == TICK_CYCLES - 1) ? '0 : tick_cnt_r + 1'b1;
        end
    end

    // Flood policer selection and verdict
    wire [FI_W-1:0] fpol = frm_service_flood_override ? frm_svc_flood_idx : frm_vlan_flood_idx;
    wire [FILL_W-1:0] f_amt = charge_calc(frm_len, frm_stripped, fgap_r[fpol], fskip_r[fpol],
        fframes_r[fpol]);
    logic [2:0] f_appl, f_closed;
    for (genvar b = 0; b < 3; b++) begin : g_fsel
        wire [FK_W-1:0] sk = FK_W'(int'(fpol) * 3 + b);
        assign f_appl[b] = |(tmask_r[b] & frm_flood_type);
        assign f_closed[b] = ffill_r[sk] > (FILL_W'(fthr_r[sk]) << FLOOD_THR_SHIFT);
    end
    wire f_excess = frm_valid && |(f_appl & f_closed);
    wire [1:0] f_step = fstep_r[fpol];
    wire f_drop = f_excess && f_step == 2'h0;
    wire [2:0] prec_sum = {1'b0, frm_prec} + {1'b0, f_step};
    wire [1:0] prec_out = f_excess ? (prec_sum[2] ? 2'h3 : prec_sum[1:0]) : frm_prec;
    wire f_add = frm_valid && !f_excess;

    // Flood bucket fill levels; a frame that exceeds no bucket charges every bucket of its policer whose type mask matches
    for (genvar k = 0; k < NUM_FLOOD * 3; k++) begin : g_fbkt
        wire [FILL_W-1:0] drain = FILL_W'(frate_r[k]) << {fgran_r[k/3], 1'b0};
        wire hit = f_add && fpol == FI_W'(k / 3) && f_appl[k%3];
        always_ff @(posedge clk) begin
            if (rst) begin
                ffill_r[k] <= '0;
            end else begin
                ffill_r[k] <= bucket_step(ffill_r[k], tick_r, drain, hit, f_amt);
            end
        end
    end

    // Access-list policer: only the one index named by the rule hit
    wire [1:0] l_tgt = ltgt_r[frm_list_idx];
    wire l_target = frm_to_cpu ? l_tgt[TGT_CPU] : l_tgt[TGT_FRONT];
    wire l_enabled = frm_valid && frm_list_hit && lrate_r[frm_list_idx] != 17'h00000 &&
        l_target;
    wire l_pipe = l_enabled && frm_pipeline_bypass;
    wire l_level = l_enabled && !frm_pipeline_bypass && frm_prec < lbyp_r[frm_list_idx];
    wire l_police = l_enabled && !frm_pipeline_bypass && !l_level;
    wire l_closed = lfill_r[frm_list_idx] >
        (FILL_W'(lthr_r[frm_list_idx]) << LIST_THR_SHIFT);
    wire l_drop = l_police && l_closed;
    wire l_add = l_police && !l_closed && !f_drop;
    wire [FILL_W-1:0] l_amt = charge_calc(frm_len, frm_stripped, lgap_r[frm_list_idx], 1'b0,
        lframes_r[frm_list_idx]);

    for (genvar j = 0; j < NUM_LIST; j++) begin : g_lbkt
        wire [FILL_W-1:0] drain = lframes_r[j] ?
            FILL_W'(lrate_r[j]) * FILL_W'(LIST_FRAME_MULT) : FILL_W'(lrate_r[j]);
        wire hit = l_add && frm_list_idx == LI_W'(j);
        always_ff @(posedge clk) begin
            if (rst) begin
                lfill_r[j] <= '0;
            end else begin
                lfill_r[j] <= bucket_step(lfill_r[j], tick_r, drain, hit, l_amt);
            end
        end
    end

    // Sticky flags: hardware set wins over a write-one clear in the same cycle
    wire [3:0] flag_set = {l_police && !l_closed, l_drop, l_level, l_pipe};
    wire [3:0] flag_clr = (reg_wr && s_ok) ? reg_wdata[3:0] : 4'h0;
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_r <= 4'h0;
        end else begin
            flags_r <= (flags_r & ~flag_clr) | flag_set;
        end
    end

    // Dual-bucket selection: rule choice first, then priority policing
    wire non_svc = frm_service_index == '0 && frm_service_policer_index == '0;
    wire dual_prio = !frm_rule_policer_select_bit && prio_en_r && non_svc;
    wire [DB_W-1:0] dual_idx = frm_rule_policer_select_bit ? frm_rule_policer_idx :
        pbase_r[frm_port] + DB_W'(frm_qos);
    wire dual_green = frm_prec <= green_r;

    // Flood statistic events for discarded and passed frames
    logic [5:0] stat_evt;
    for (genvar t = 0; t < 3; t++) begin : g_stat
        wire seen = frm_valid && |f_appl && frm_flood_type[t];
        assign stat_evt[t] = seen && f_drop && stat_mask_r[t];
        assign stat_evt[t+3] = seen && !f_drop && stat_mask_r[t+3];
    end

    // Verdict registers; outputs stand for one cycle after the request
    always_ff @(posedge clk) begin
        if (rst) begin
            res_valid <= 1'b0;
            res_drop <= 1'b0;
            res_prec <= 2'h0;
            res_dual_valid <= 1'b0;
            res_dual_idx <= '0;
            res_dual_green <= 1'b0;
            flood_stat_evt <= 6'h00;
            list_drop_evt <= 1'b0;
            list_drop_port_evt <= 1'b0;
        end else begin
            res_valid <= frm_valid;
            res_drop <= f_drop || l_drop;
            res_prec <= prec_out;
            res_dual_valid <= frm_valid && (frm_rule_policer_select_bit || dual_prio);
            res_dual_idx <= dual_idx;
            res_dual_green <= dual_green;
            flood_stat_evt <= stat_evt;
            list_drop_evt <= l_drop;
            list_drop_port_evt <= l_drop && port_cnt_r;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    wire [DATA_W-1:0] glob_word = DATA_W'({tmask_r[2], 1'b0, tmask_r[1], 1'b0, tmask_r[0],
        2'b00, stat_mask_r, 4'h0, port_cnt_r, green_r, prio_en_r});
    wire [DATA_W-1:0] fcfg_word = DATA_W'({fframes_r[f_idx], fskip_r[f_idx], fgap_r[f_idx],
        fstep_r[f_idx], fgran_r[f_idx]});
    wire [DATA_W-1:0] fbkt_word = DATA_W'({5'h00, frate_r[f_bkt], 9'h000, fthr_r[f_bkt]});
    wire [DATA_W-1:0] lctl_word = DATA_W'({lgap_r[l_idx], 3'h0, lbyp_r[l_idx],
        lframes_r[l_idx], ltgt_r[l_idx]});
    wire [DATA_W-1:0] lrate_word = DATA_W'({2'b00, lthr_r[l_idx], 7'h00, lrate_r[l_idx]});
    wire [DATA_W-1:0] rd_nxt = g_ok ? glob_word : s_ok ? DATA_W'(flags_r) :
        f_ok ? (f_word == 2'h0 ? fcfg_word : fbkt_word) :
        l_ok ? (l_word ? lrate_word : lctl_word) :
        p_ok ? DATA_W'(pbase_r[p_idx]) : '0;
    always_ff @(posedge clk) begin
        if (rst) begin
            reg_rdata <= '0;
        end else begin
            reg_rdata <= reg_rd ? rd_nxt : '0;
        end
    end

    // Checks on the frame verdict path
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_flood_excess;
        frm_valid && f_excess;
    endsequence
    property p_flood_discard;
        s_flood_excess ##0 (f_step == 2'h0) |=> res_valid && res_drop;
    endproperty
    a_flood_discard: assert property (p_flood_discard) else $error("excess not dropped");
    property p_flood_raise;
        s_flood_excess ##0 (f_step != 2'h0) ##1 res_valid |->
            res_prec == (({1'b0, $past(frm_prec)} + {1'b0, $past(f_step)}) > 3'h3 ?
            2'h3 : $past(frm_prec) + $past(f_step));
    endproperty
    a_flood_raise: assert property (p_flood_raise) else $error("bad raised precedence");
    property p_level_bypass;
        l_enabled && !frm_pipeline_bypass && frm_prec < lbyp_r[frm_list_idx] |=>
            !list_drop_evt && flags_r[FLG_LEVEL];
    endproperty
    a_level_bypass: assert property (p_level_bypass) else $error("bypass failed");
    property p_port_count;
        list_drop_port_evt |-> list_drop_evt && $past(port_cnt_r);
    endproperty
    a_port_count: assert property (p_port_count) else $error("port count without drop");
    property p_rule_first;
        frm_valid && frm_rule_policer_select_bit |=>
            res_dual_valid && res_dual_idx == $past(frm_rule_policer_idx);
    endproperty
    a_rule_first: assert property (p_rule_first) else $error("rule index lost");
    property p_prio_pick;
        frm_valid && !frm_rule_policer_select_bit && prio_en_r && non_svc |=>
            res_dual_valid && res_dual_idx == $past(pbase_r[frm_port]) + DB_W'($past(frm_qos));
    endproperty
    a_prio_pick: assert property (p_prio_pick) else $error("bad priority index");
    property p_green;
        frm_valid ##1 res_dual_valid |-> res_dual_green == ($past(frm_prec) <= $past(green_r));
    endproperty
    a_green: assert property (p_green) else $error("bad color");
    property p_drop_sticky;
        flags_r[FLG_DROP] && !flag_clr[FLG_DROP] |=> flags_r[FLG_DROP] [*1];
    endproperty
    a_drop_sticky: assert property (p_drop_sticky) else $error("drop flag lost");
    property p_stat_disc;
        frm_valid && |f_appl && f_drop && frm_flood_type[0] && stat_mask_r[0] |=>
            flood_stat_evt[0] && !flood_stat_evt[3];
    endproperty
    a_stat_disc: assert property (p_stat_disc) else $error("missed discard count");
endmodule : fap_policer
`default_nettype wire

//--- fap_feed.sv
// Frame source standing in for the classification pipeline
`timescale 1ns/1ps
`default_nettype none
module fap_feed (
    input wire logic clk,
    output logic frm_valid,
    output logic [13:0] frm_len,
    output logic [2:0] frm_flood_type,
    output logic [1:0] frm_prec,
    output logic frm_list_hit,
    output logic frm_to_cpu,
    output logic [2:0] frm_port,
    output logic [2:0] frm_qos,
    output logic frm_rule_policer_select_bit,
    output logic [9:0] frm_rule_policer_idx
);
    // Quiet request at time zero
    initial begin
        frm_valid = 1'b0;
        {frm_len, frm_flood_type, frm_prec, frm_list_hit, frm_to_cpu} = '0;
        {frm_port, frm_qos, frm_rule_policer_select_bit, frm_rule_policer_idx} = '0;
    end
    // One request per call; length, flood type and precedence flip when idle so stale values are never trusted
    task automatic send(input logic [13:0] len, input logic [2:0] ft, input logic [1:0] pr,
        input logic hit, input logic cpu, input logic [2:0] port, input logic [2:0] qos,
        input logic rsel, input logic [9:0] ridx);
        @(posedge clk);
        frm_valid <= 1'b1;
        {frm_len, frm_flood_type, frm_prec, frm_list_hit, frm_to_cpu} <= {len, ft, pr, hit, cpu};
        {frm_port, frm_qos, frm_rule_policer_select_bit, frm_rule_policer_idx} <= {port, qos, rsel, ridx};
        @(posedge clk);
        frm_valid <= 1'b0;
        {frm_len, frm_flood_type, frm_prec} <= ~{len, ft, pr};
        #1;
    endtask : send
endmodule : fap_feed
`default_nettype wire

//--- test_flood_and_acl_policers.sv
// Self-checking bench for the flood and access-list policing stage
`timescale 1ns/1ps
`default_nettype none
module test_flood_and_acl_policers;
    logic clk, rst, reg_wr, reg_rd, frm_valid, frm_list_hit, frm_to_cpu, rsel;
    logic res_valid, res_drop, res_dual_valid, res_dual_green, list_drop_evt, list_drop_port_evt;
    logic [11:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [13:0] frm_len;
    logic [2:0] frm_flood_type, frm_port, frm_qos;
    logic [1:0] frm_prec, res_prec;
    logic [9:0] ridx, res_dual_idx;
    logic [5:0] flood_stat_evt;
    logic byp_pipe, sfo;
    logic [2:0] lidx;
    logic [1:0] sfidx;
    int err_total, n_checks;
    wire logic [11:0] fr = {res_valid, res_drop, res_prec, flood_stat_evt, list_drop_evt,
        list_drop_port_evt};
    // Leak tick kept far beyond the run so bucket fills stay exactly predictable
    fap_policer #(.TICK_CYCLES(4000)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .frm_valid, .frm_len, .frm_stripped(7'h00), .frm_prec, .frm_flood_type,
        .frm_vlan_flood_idx(2'h0), .frm_service_flood_override(sfo), .frm_svc_flood_idx(sfidx),
        .frm_to_cpu, .frm_list_hit, .frm_list_idx(lidx), .frm_pipeline_bypass(byp_pipe),
        .frm_service_index(12'h000), .frm_service_policer_index(10'h000),
        .frm_rule_policer_select_bit(rsel), .frm_rule_policer_idx(ridx), .frm_port, .frm_qos,
        .res_valid, .res_drop, .res_prec, .res_dual_valid, .res_dual_idx, .res_dual_green,
        .flood_stat_evt, .list_drop_evt, .list_drop_port_evt);
    fap_feed p (.clk, .frm_valid, .frm_len, .frm_flood_type, .frm_prec, .frm_list_hit,
        .frm_to_cpu, .frm_port, .frm_qos, .frm_rule_policer_select_bit(rsel),
        .frm_rule_policer_idx(ridx));
    // Clock at 50 ns
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            $display("unexpected t=%0t got=%h exp=%h", $time, g, e);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e);
    endtask : rd
    // Side fields of the next request, set one edge ahead so they stand through it
    task automatic side(input logic pb, input logic [2:0] li, input logic so,
        input logic [1:0] si);
        @(posedge clk);
        {byp_pipe, lidx, sfo, sfidx} <= {pb, li, so, si};
    endtask : side
    task automatic t_regs;
        rd(12'h000, 32'h6);
        wr(12'h400, 32'h3);
        rd(12'h400, 32'h3);
        rd(12'h3f0, 32'h0);
    endtask : t_regs
    // Bucket 0 watches broadcast; zero limit closes once anything is charged
    task automatic t_flood;
        wr(12'h000, 32'h00013f06);
        wr(12'h400, 32'h0);
        p.send(14'd64, 3'h1, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h0, 6'h08, 2'h0});
        p.send(14'd64, 3'h1, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b1, 2'h0, 6'h01, 2'h0});
        wr(12'h400, 32'h4);
        p.send(14'd64, 3'h1, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h1, 6'h08, 2'h0});
        p.send(14'd64, 3'h4, 2'h2, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h2, 6'h00, 2'h0});
        side(1'b0, 3'h0, 1'b1, 2'h1);
        p.send(14'd64, 3'h1, 2'h0, 1'b0, 1'b0, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h0, 6'h08, 2'h0});
    endtask : t_flood
    // CPU-only list policer in frame mode with no burst allowance, then its bypass paths
    task automatic t_list;
        wr(12'h000, 32'h00013f0e);
        side(1'b0, 3'h0, 1'b0, 2'h0);
        wr(12'h800, 32'h6);
        wr(12'h804, 32'h1);
        p.send(14'd900, 3'h0, 2'h0, 1'b1, 1'b1, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h0, 6'h00, 2'h0});
        p.send(14'd900, 3'h0, 2'h0, 1'b1, 1'b1, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b1, 2'h0, 6'h00, 2'h3});
        p.send(14'd900, 3'h0, 2'h0, 1'b1, 1'b0, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h0, 6'h00, 2'h0});
        rd(12'h004, 32'hc);
        wr(12'h004, 32'hf);
        rd(12'h004, 32'h0);
        // Closed policer 0 must let these pass: pipeline bypass, another index, low level
        side(1'b1, 3'h0, 1'b0, 2'h0);
        p.send(14'd900, 3'h0, 2'h0, 1'b1, 1'b1, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h0, 6'h00, 2'h0});
        side(1'b0, 3'h1, 1'b0, 2'h0);
        p.send(14'd900, 3'h0, 2'h0, 1'b1, 1'b1, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h0, 6'h00, 2'h0});
        side(1'b0, 3'h0, 1'b0, 2'h0);
        wr(12'h800, 32'h16);
        p.send(14'd900, 3'h0, 2'h1, 1'b1, 1'b1, 3'h0, 3'h0, 1'b0, 10'h0);
        chk(fr, {1'b1, 1'b0, 2'h1, 6'h00, 2'h0});
        rd(12'h004, 32'h3);
    endtask : t_list
    // Port base plus class, then a rule-selected policer overriding it
    task automatic t_prio;
        wr(12'h000, 32'h00013f01);
        wr(12'hc08, 32'h40);
        p.send(14'd100, 3'h0, 2'h1, 1'b0, 1'b0, 3'h2, 3'h3, 1'b0, 10'h0);
        chk({res_dual_valid, res_dual_idx, res_dual_green}, {1'b1, 10'h043, 1'b0});
        p.send(14'd100, 3'h0, 2'h0, 1'b0, 1'b0, 3'h2, 3'h3, 1'b1, 10'h155);
        chk({res_dual_valid, res_dual_idx, res_dual_green}, {1'b1, 10'h155, 1'b1});
    endtask : t_prio
    task automatic conclude;
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude
    // Reset for three cycles, then the scenarios in turn
    initial begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 46'h0};
        {byp_pipe, lidx, sfo, sfidx} = 7'h00;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs();
        t_flood();
        t_list();
        t_prio();
        conclude();
    end
    // Watchdog well past the few dozen cycles the scenarios need
    initial begin
        #(3000 * 50);
        err_total++;
        conclude();
    end
endmodule : test_flood_and_acl_policers
`default_nettype wire
